// *** src/adc_autoscan_sequencer.v ***
// Summary of operation
// R1 - one channel conversion lasts 138 divided ticks
// R2 - sampling phase lasts the first 84 divided ticks
// R3 - three-bit divide select picks the division factor; 100 gives 8, 111 gives 1
// R4 - each result is an 8-bit code taken from the converter core
// R5 - eight input channels, each with its own result register
// R6 - repeat mode bit one selects continuous, zero selects single mode
// R7 - conversion starts at first channel field and steps up to channel 7
// R8 - go bit set by software or trigger starts the scan
// R9 - single mode clears go after channel 7, raises end of conversion, idles
// R10 - continuous mode restarts at first channel until software clears go
// R11 - end of conversion request raised each time channel 7 completes
// R12 - new result overwrites old one, no overrun flag
// R13 - two window watchdogs flag out-of-window results and record which bound
// R14 - bias enable bit cleared means low-power idle, no conversions
// R15 - two maskable requests, fixed priority, programmable level up to 7
// R16 - external trigger pin or timer event may start a scan
// R17 - triggers ignored while go is set
// R18 - channels 6 and 7 watched; in range when below upper, at or above lower
// R19 - watchdog request served before end of conversion, which stays pending
// R20 - software sets bias enable 60 us before first start; halt clears it
// R21 - division factors held in a parameterised lookup table
`timescale 1ns/10ps
`default_nettype none
`include "adc_autoscan_map.vh"

module adc_autoscan_sequencer #(
	parameter [4:0] FDF_000 = 5'd16,
	parameter [4:0] FDF_001 = 5'd14,
	parameter [4:0] FDF_010 = 5'd12,
	parameter [4:0] FDF_011 = 5'd10,
	parameter [4:0] FDF_100 = 5'd8,
	parameter [4:0] FDF_101 = 5'd6,
	parameter [4:0] FDF_110 = 5'd4,
	parameter [4:0] FDF_111 = 5'd1
) (
	input wire clk_in, // 40 MHz clock
	input wire nrst_in, // synchronous reset, active low
	input wire [4:0] addr_in, // register address
	input wire [7:0] wdata_in, // write data
	input wire wr_in, // write strobe
	input wire rd_in, // read strobe
	output reg [7:0] rdata_out, // read data, cycle after rd_in
	input wire ext_trig_in, // external trigger pin
	input wire int_trig_in, // timer trigger event
	input wire halt_in, // core halt entry
	input wire [7:0] sar_result_in, // converter core result code
	output reg [2:0] channel_out, // multiplexer channel select
	output reg sample_out, // sample-and-hold tracking
	output reg convert_out, // conversion in progress
	output reg bias_out, // analog bias enable
	output reg irq_out, // interrupt request
	output reg irq_vector_out, // 0 watchdog, 1 end of conversion
	output reg [2:0] irq_level_out // interrupt priority level
);

	localparam ST_IDLE = 1'b0;
	localparam ST_CONV = 1'b1;

	reg state_q;
	reg [7:0] data_q [0:7];
	reg [7:0] lt6_q;
	reg [7:0] lt7_q;
	reg [7:0] ut6_q;
	reg [7:0] ut7_q;
	reg [3:0] cmp_q;
	reg go_q;
	reg repeat_q;
	reg ext_en_q;
	reg int_en_q;
	reg bias_q;
	reg [2:0] first_q;
	reg [2:0] div_sel_q;
	reg eoc_mask_q;
	reg win_mask_q;
	reg eoc_pend_q;
	reg win_pend_q;
	reg [2:0] level_q;
	reg [2:0] chan_q;
	reg [4:0] pre_q;
	reg [7:0] tick_q;
	reg ext_prev_q;
	reg int_prev_q;

	// division factor lookup
	function [4:0] fdf_of;
		input [2:0] sel;
		begin
			case (sel)
				3'h0: fdf_of = FDF_000;
				3'h1: fdf_of = FDF_001;
				3'h2: fdf_of = FDF_010;
				3'h3: fdf_of = FDF_011;
				3'h4: fdf_of = FDF_100;
				3'h5: fdf_of = FDF_101;
				3'h6: fdf_of = FDF_110;
				default: fdf_of = FDF_111;
			endcase
		end
	endfunction

	// window check: high bit upper breach, low bit lower breach
	function [1:0] window_of;
		input [7:0] v;
		input [7:0] lo;
		input [7:0] up;
		begin
			window_of = {(v >= up), (v < lo)};
		end
	endfunction

	wire [4:0] fdf = fdf_of(div_sel_q); // see R3 see R21
	// >= so a divide change mid-conversion cannot let the prescaler run past
	wire tick = (pre_q >= fdf - 5'd1);
	wire conv_end = (state_q == ST_CONV) && tick && (tick_q == `CONV_TICKS - 8'd1); // see R1
	wire last_ch = (chan_q == `LAST_CH);

	wire ext_edge = ext_en_q && ext_trig_in && !ext_prev_q;
	wire int_edge = int_en_q && int_trig_in && !int_prev_q;
	wire trig = (ext_edge || int_edge) && !go_q; // see R16 see R17

	wire wr_ctl = wr_in && (addr_in == `ADDR_CTL);
	wire wr_irq = wr_in && (addr_in == `ADDR_IRQ);
	wire sw_go_set = wr_ctl && wdata_in[`CTL_GO];
	wire sw_go_clr = wr_ctl && !wdata_in[`CTL_GO];
	wire wr_cfg = wr_in && (addr_in == `ADDR_CFG);
	wire wr_lt6 = wr_in && (addr_in == `ADDR_LT6);
	wire wr_lt7 = wr_in && (addr_in == `ADDR_LT7);
	wire wr_ut6 = wr_in && (addr_in == `ADDR_UT6);
	wire wr_ut7 = wr_in && (addr_in == `ADDR_UT7);
	wire rd_result = (addr_in < `ADDR_LT6);

	wire [1:0] win6 = window_of(sar_result_in, lt6_q, ut6_q); // see R18
	wire [1:0] win7 = window_of(sar_result_in, lt7_q, ut7_q); // see R18
	wire watched = conv_end && (chan_q >= `WATCH_CH_A);
	wire [1:0] win_hit = (chan_q == `LAST_CH) ? win7 : win6;
	wire win_event = watched && (win_hit != 2'b00); // see R13
	wire eoc_event = conv_end && last_ch; // see R11

	wire [3:0] cmp_set = !watched ? 4'h0 :
		(chan_q == `LAST_CH) ? {win7, 2'b00} : {2'b00, win6};

	// trigger edge history
	always @(posedge clk_in) begin
		if (!nrst_in) begin
			ext_prev_q <= 1'b0;
			int_prev_q <= 1'b0;
		end else begin
			ext_prev_q <= ext_trig_in;
			int_prev_q <= int_trig_in;
		end
	end

	// control, configuration and threshold registers
	always @(posedge clk_in) begin
		if (!nrst_in) begin
			repeat_q <= 1'b0;
			ext_en_q <= 1'b0;
			int_en_q <= 1'b0;
			bias_q <= 1'b0;
			first_q <= 3'h0;
			div_sel_q <= 3'h0;
			eoc_mask_q <= 1'b0;
			win_mask_q <= 1'b0;
			level_q <= 3'h0;
			lt6_q <= `THR_RESET;
			lt7_q <= `THR_RESET;
			ut6_q <= `THR_RESET;
			ut7_q <= `THR_RESET;
		end else begin
			if (wr_ctl) begin
				repeat_q <= wdata_in[`CTL_REPEAT]; // see R6
				ext_en_q <= wdata_in[`CTL_EXT_EN];
				int_en_q <= wdata_in[`CTL_INT_EN];
				bias_q <= wdata_in[`CTL_BIAS];
			end
			if (halt_in)
				bias_q <= 1'b0; // see R20
			if (wr_cfg) begin
				first_q <= wdata_in[`CFG_FIRST_LO +: 3]; // see R7
				div_sel_q <= wdata_in[`CFG_DIV_LO +: 3]; // see R3
			end
			if (wr_irq) begin
				eoc_mask_q <= wdata_in[`IRQ_EOC_MASK];
				win_mask_q <= wdata_in[`IRQ_WIN_MASK];
				level_q <= wdata_in[`IRQ_LVL_LO +: 3]; // see R15
			end
			if (wr_lt6)
				lt6_q <= wdata_in;
			if (wr_lt7)
				lt7_q <= wdata_in;
			if (wr_ut6)
				ut6_q <= wdata_in;
			if (wr_ut7)
				ut7_q <= wdata_in;
		end
	end

	// go bit: hardware set wins over any clear
	always @(posedge clk_in) begin
		if (!nrst_in) begin
			go_q <= 1'b0;
		end else if (trig || sw_go_set) begin
			go_q <= 1'b1; // see R8
		end else if (sw_go_clr) begin
			go_q <= 1'b0; // see R10
		end else if (eoc_event && !repeat_q) begin
			go_q <= 1'b0; // see R9
		end
	end

	// sequencer
	always @(posedge clk_in) begin
		if (!nrst_in) begin
			state_q <= ST_IDLE;
			chan_q <= 3'h0;
			pre_q <= 5'h00;
			tick_q <= 8'h00;
		end else begin
			case (state_q)
				ST_IDLE: begin
					pre_q <= 5'h00;
					tick_q <= 8'h00;
					if (go_q && bias_q) begin // see R14
						chan_q <= first_q; // see R7
						state_q <= ST_CONV;
					end
				end
				ST_CONV: begin
					if (!go_q || !bias_q) begin
						state_q <= ST_IDLE;
					end else begin
						pre_q <= tick ? 5'h00 : pre_q + 5'd1;
						if (tick)
							tick_q <= conv_end ? 8'h00 : tick_q + 8'd1;
						if (conv_end) begin
							if (!last_ch)
								chan_q <= chan_q + 3'd1; // see R7
							else if (repeat_q)
								chan_q <= first_q; // see R10
							else
								state_q <= ST_IDLE; // see R9
						end
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// result registers
	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : res
			localparam [2:0] CH_G = g;
			wire load_g = conv_end && (chan_q == CH_G);
			wire poke_g = wr_in && (addr_in == `ADDR_DATA0 + {2'b00, CH_G});
			always @(posedge clk_in) begin
				if (!nrst_in)
					data_q[g] <= 8'h00;
				else if (load_g)
					data_q[g] <= sar_result_in; // see R4 see R5 see R12
				else if (poke_g)
					data_q[g] <= wdata_in;
			end
		end
	endgenerate

	// pending flags and compare result; hardware set wins
	always @(posedge clk_in) begin
		if (!nrst_in) begin
			eoc_pend_q <= 1'b0;
			win_pend_q <= 1'b0;
			cmp_q <= 4'h0;
		end else begin
			if (eoc_event)
				eoc_pend_q <= 1'b1; // see R9 see R11
			else if (wr_irq)
				eoc_pend_q <= wdata_in[`IRQ_EOC_PEND];
			if (win_event)
				win_pend_q <= 1'b1; // see R13
			else if (wr_irq)
				win_pend_q <= wdata_in[`IRQ_WIN_PEND];
			if (win_event)
				cmp_q <= cmp_q | cmp_set; // see R13
			else if (wr_irq && !wdata_in[`IRQ_WIN_PEND])
				cmp_q <= 4'h0;
		end
	end

	// interrupt outputs
	always @(posedge clk_in) begin
		if (!nrst_in) begin
			irq_out <= 1'b0;
			irq_vector_out <= `VEC_WIN;
			irq_level_out <= 3'h0;
		end else begin
			irq_out <= (win_pend_q && win_mask_q) || (eoc_pend_q && eoc_mask_q);
			irq_vector_out <= (win_pend_q && win_mask_q) ? `VEC_WIN : `VEC_EOC; // see R19
			irq_level_out <= level_q; // see R15
		end
	end

	// converter core controls
	always @(posedge clk_in) begin
		if (!nrst_in) begin
			channel_out <= 3'h0;
			sample_out <= 1'b0;
			convert_out <= 1'b0;
			bias_out <= 1'b0;
		end else begin
			channel_out <= chan_q;
			sample_out <= (state_q == ST_CONV) && (tick_q < `SAMPLE_TICKS); // see R2
			convert_out <= (state_q == ST_CONV);
			bias_out <= bias_q;
		end
	end

	// register read port
	always @(posedge clk_in) begin
		if (!nrst_in) begin
			rdata_out <= 8'h00;
		end else if (rd_in) begin
			case (addr_in)
				`ADDR_LT6: rdata_out <= lt6_q;
				`ADDR_LT7: rdata_out <= lt7_q;
				`ADDR_UT6: rdata_out <= ut6_q;
				`ADDR_UT7: rdata_out <= ut7_q;
				`ADDR_CMP: rdata_out <= {cmp_q, 4'h0};
				`ADDR_CTL: rdata_out <= {3'h0, bias_q, int_en_q, ext_en_q, repeat_q, go_q};
				`ADDR_CFG: rdata_out <= {1'b0, div_sel_q, 1'b0, first_q};
				`ADDR_IRQ: rdata_out <= {eoc_pend_q, win_pend_q, 1'b0, level_q,
					win_mask_q, eoc_mask_q};
				default: rdata_out <= rd_result ? data_q[addr_in[2:0]] : 8'h00;
			endcase
		end else begin
			rdata_out <= 8'h00;
		end
	end

endmodule
`default_nettype wire

// *** src/adc_autoscan_map.vh ***
`ifndef ADC_AUTOSCAN_MAP_VH
`define ADC_AUTOSCAN_MAP_VH

// register offsets
`define ADDR_DATA0 5'h00
`define ADDR_LT6 5'h08
`define ADDR_LT7 5'h09
`define ADDR_UT6 5'h0a
`define ADDR_UT7 5'h0b
`define ADDR_CMP 5'h0c
`define ADDR_CTL 5'h0d
`define ADDR_CFG 5'h0e
`define ADDR_IRQ 5'h0f

// control logic register fields
`define CTL_GO 0
`define CTL_REPEAT 1
`define CTL_EXT_EN 2
`define CTL_INT_EN 3
`define CTL_BIAS 4

// configuration register fields
`define CFG_FIRST_LO 0
`define CFG_DIV_LO 4

// interrupt control register fields
`define IRQ_EOC_MASK 0
`define IRQ_WIN_MASK 1
`define IRQ_LVL_LO 2
`define IRQ_WIN_PEND 6
`define IRQ_EOC_PEND 7

// compare result flag positions
`define CMP_LO6 4
`define CMP_UP6 5
`define CMP_LO7 6
`define CMP_UP7 7

// conversion timing, in divided ticks, and last and first watched channel
`define CONV_TICKS 8'd138
`define SAMPLE_TICKS 8'd84
`define LAST_CH 3'h7
`define WATCH_CH_A 3'h6

// interrupt vector codes
`define VEC_WIN 1'b0
`define VEC_EOC 1'b1

// reset values
`define CTL_RESET 8'h00
`define CFG_RESET 8'h00
`define IRQ_RESET 8'h00
`define THR_RESET 8'h00

`endif

// *** tb/analog_source.sv ***
`timescale 1ns/10ps
`default_nettype none
module analog_source (
	input wire logic clk_in, // clock
	input wire logic [2:0] channel_in, // selected input
	input wire logic convert_in, // conversion running
	output logic [7:0] level_out // code to converter
);
	logic [7:0] idle_q = 8'h00;
	// no stale code outside conversions
	always @(posedge clk_in) begin
		idle_q <= ~idle_q;
	end
	assign level_out = convert_in ? {1'b1, channel_in, 1'b0, channel_in} : idle_q;
endmodule
`default_nettype wire

// *** tb/adc_autoscan_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "adc_autoscan_map.vh"
module adc_autoscan_checker (
	input wire clk_in, // clock
	input wire nrst_in, // reset
	input wire [4:0] addr_in, // address
	input wire [7:0] wdata_in, // write data
	input wire wr_in, // write
	input wire rd_in, // read
	input wire [7:0] rdata_out, // read data
	input wire halt_in, // halt
	input wire [2:0] channel_out, // channel
	input wire sample_out, // sampling
	input wire convert_out, // converting
	input wire bias_out, // bias
	input wire irq_out, // request
	input wire irq_vector_out // vector
);
	default clocking @(posedge clk_in);
	endclocking
	default disable iff (!nrst_in);
	wire ctl_wr = wr_in && addr_in == `ADDR_CTL;
	wire irq_wr = wr_in && addr_in == `ADDR_IRQ;
	property p_rd_idle;
		!rd_in |=> rdata_out == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
	property p_unmapped;
		rd_in && addr_in[4] |=> rdata_out == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_sample_conv;
		sample_out |-> convert_out;
	endproperty
	a_sample_conv: assert property (p_sample_conv) else $error("sampling outside conversion");
	property p_chan_step;
		convert_out && $past(convert_out) && $changed(channel_out) && $past(channel_out) != 3'h7
			|-> channel_out == $past(channel_out) + 3'h1;
	endproperty
	a_chan_step: assert property (p_chan_step) else $error("channel skipped");
	property p_go_start;
		ctl_wr && wdata_in[`CTL_GO] && wdata_in[`CTL_BIAS] && !halt_in && !convert_out
			|-> ##[1:3] convert_out;
	endproperty
	a_go_start: assert property (p_go_start) else $error("scan did not start");
	property p_go_stop;
		ctl_wr && !wdata_in[`CTL_GO] |-> ##[1:3] !convert_out;
	endproperty
	a_go_stop: assert property (p_go_stop) else $error("scan did not stop");
	property p_halt_bias;
		halt_in |-> ##[1:2] !bias_out;
	endproperty
	a_halt_bias: assert property (p_halt_bias) else $error("bias kept in halt");
	property p_halt_idle;
		halt_in [*4] |-> !convert_out;
	endproperty
	a_halt_idle: assert property (p_halt_idle) else $error("converting while powered down");
	property p_mask_off;
		irq_wr && wdata_in[1:0] == 2'b00 ##1 !irq_wr |-> ##1 !irq_out;
	endproperty
	a_mask_off: assert property (p_mask_off) else $error("masked request raised");
	property p_win_first;
		irq_wr && wdata_in[`IRQ_WIN_PEND] && wdata_in[`IRQ_WIN_MASK] ##1 !irq_wr
			|-> ##1 irq_out && irq_vector_out == `VEC_WIN;
	endproperty
	a_win_first: assert property (p_win_first) else $error("watchdog not served first");
	c_scan_end: cover property ($fell(convert_out));
	c_eoc_vec: cover property (irq_out && irq_vector_out == `VEC_EOC);
	c_bias_off: cover property ($fell(bias_out));
endmodule
bind adc_autoscan_sequencer adc_autoscan_checker chk_u (.clk_in, .nrst_in, .addr_in, .wdata_in,
	.wr_in, .rd_in, .rdata_out, .halt_in, .channel_out, .sample_out, .convert_out, .bias_out,
	.irq_out, .irq_vector_out);
`default_nettype wire

// *** tb/adc_autoscan_sequencer_test.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "adc_autoscan_map.vh"
module adc_autoscan_sequencer_test;
	logic clk_in = 1'b0;
	logic nrst_in = 1'b0;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic ext_trig_in = 1'b0;
	logic int_trig_in = 1'b0;
	logic halt_in = 1'b0;
	logic [4:0] addr_in = 5'h00;
	logic [7:0] wdata_in = 8'h00;
	wire [7:0] rdata_out, sar_result_in;
	wire [2:0] channel_out, irq_level_out;
	wire sample_out, convert_out, bias_out, irq_out, irq_vector_out;
	int failures = 0;
	int samples_checked = 0;
	int conv_n = 0;
	int samp_n = 0;
	adc_autoscan_sequencer dut_u (.clk_in, .nrst_in, .addr_in, .wdata_in, .wr_in, .rd_in,
		.rdata_out, .ext_trig_in, .int_trig_in, .halt_in, .sar_result_in, .channel_out,
		.sample_out, .convert_out, .bias_out, .irq_out, .irq_vector_out, .irq_level_out);
	analog_source src_u (.clk_in, .channel_in(channel_out), .convert_in(convert_out),
		.level_out(sar_result_in));
	always #12.5 clk_in = ~clk_in;
	always @(posedge clk_in) begin
		if (convert_out) conv_n <= conv_n + 1;
		if (sample_out) samp_n <= samp_n + 1;
	end
	task automatic results();
		$display("comparisons %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		addr_in <= a;
		wdata_in <= d;
		rd_in <= 1'b0;
		wr_in <= 1'b1;
		@(posedge clk_in);
	endtask
	task automatic idle(input int n);
		wr_in <= 1'b0;
		repeat (n) @(posedge clk_in);
	endtask
	task automatic chk_rd(input logic [4:0] a, input logic [7:0] exp);
		addr_in <= a;
		wr_in <= 1'b0;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		@(negedge clk_in);
		check("register", rdata_out, exp);
		@(posedge clk_in);
	endtask
	task automatic wait_idle();
		int i;
		for (i = 0; i < 2000 && convert_out !== 1'b0; i++) @(posedge clk_in);
		if (i == 2000) begin
			failures++;
			results();
		end
	endtask
	initial begin
		int c0;
		int s0;
		repeat (3) @(posedge clk_in);
		nrst_in <= 1'b1;
		@(posedge clk_in);
		chk_rd(`ADDR_CTL, `CTL_RESET);
		chk_rd(`ADDR_CMP, 8'h00);
		chk_rd(5'h13, 8'h00);
		wr(`ADDR_LT6, 8'h10);
		wr(`ADDR_UT6, 8'hf0);
		wr(`ADDR_LT7, 8'h10);
		wr(`ADDR_UT7, 8'hf7);
		wr(5'h06, 8'h55);
		wr(`ADDR_CFG, 8'h76);
		wr(`ADDR_IRQ, 8'h0f);
		wr(`ADDR_CTL, 8'h10);
		idle(2400);
		check("bias", bias_out, 1'b1);
		check("level", irq_level_out, 3'h3);
		c0 = conv_n;
		s0 = samp_n;
		wr(`ADDR_CTL, 8'h11);
		idle(4);
		wait_idle();
		idle(2);
		check("conversion cycles", conv_n - c0, 2 * 138);
		check("sample cycles", samp_n - s0, 2 * 84);
		chk_rd(`ADDR_CTL, 8'h10);
		chk_rd(5'h06, 8'he6);
		chk_rd(5'h07, 8'hf7);
		chk_rd(5'h05, 8'h00);
		chk_rd(`ADDR_CMP, 8'h80);
		chk_rd(`ADDR_IRQ, 8'hcf);
		check("vector", irq_vector_out, `VEC_WIN);
		wr(`ADDR_IRQ, 8'h8f);
		idle(3);
		check("vector", irq_vector_out, `VEC_EOC);
		chk_rd(`ADDR_CMP, 8'h00);
		wr(`ADDR_IRQ, 8'h0c);
		idle(3);
		check("request", irq_out, 1'b0);
		wr(`ADDR_IRQ, 8'h4f);
		idle(3);
		check("vector", irq_vector_out, `VEC_WIN);
		wr(`ADDR_IRQ, 8'h0c);
		wr(`ADDR_CTL, 8'h16);
		idle(2);
		ext_trig_in <= 1'b1;
		idle(2);
		ext_trig_in <= 1'b0;
		idle(700);
		chk_rd(`ADDR_CTL, 8'h17);
		chk_rd(`ADDR_IRQ, 8'hcc);
		wr(`ADDR_CTL, 8'h16);
		idle(4);
		check("converting", convert_out, 1'b0);
		wr(`ADDR_CTL, 8'h18);
		idle(2);
		int_trig_in <= 1'b1;
		idle(2);
		int_trig_in <= 1'b0;
		chk_rd(`ADDR_CTL, 8'h19);
		wait_idle();
		chk_rd(`ADDR_CTL, 8'h18);
		halt_in <= 1'b1;
		idle(3);
		check("bias", bias_out, 1'b0);
		chk_rd(`ADDR_CTL, 8'h08);
		results();
	end
endmodule
`default_nettype wire
